// >>> flash_protect_pkg.sv
// constants for the flash protection controller
package flash_protect_pkg;
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   // register offsets (word index into byte address)
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h4;
   localparam logic [3:0] REG_WDATA = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hC;
   // control fields
   localparam int CTRL_GO = 0;
   localparam int CTRL_OP_LSB = 1;
   localparam int CTRL_OP_W = 3;
   localparam int CTRL_ALT = 4;
   localparam int CTRL_WGUARD = 5;
   // status fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_VERIFIED = 1;
   localparam int STAT_LOCKIND = 2;
   localparam int STAT_SECMAP = 3;
   localparam int STAT_RDATA_LSB = 16;
   // operations
   localparam logic [2:0] OP_PROTECT = 3'h0;
   localparam logic [2:0] OP_UNPROTECT = 3'h1;
   localparam logic [2:0] OP_VERIFY = 3'h2;
   localparam logic [2:0] OP_WRITE = 3'h3;
   localparam logic [2:0] OP_READ = 3'h4;
   localparam logic [2:0] OP_TEMP_ON = 3'h5;
   localparam logic [2:0] OP_TEMP_OFF = 3'h6;
   // address bits used by protect selection, and the lock indicator data bit
   localparam int BIT_SEL = 6;
   localparam int BIT_ONE = 1;
   localparam int BIT_ZERO = 0;
   localparam int BIT_LOCKIND = 7;
   // bus cycle phase length
   localparam int T_PHASE_NS = 100;
   localparam int CLK_NS = 20;
   localparam logic [3:0] PHASE_CYC = 4'((T_PHASE_NS + CLK_NS - 1) / CLK_NS);
   typedef enum {S_IDLE, S_SETUP, S_STROBE, S_HOLD} fsm_t;
endpackage

// >>> flash_protect_host.sv
// host-side controller driving the flash protection pins
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
// Behaviour
// [R1] device refuses program or erase in protected groups
// [R2] protection held per group of adjacent sectors
// [R3] in-system protect: elevated reset, select bit low, bit one high, bit zero low
// [R4] in-system unprotect: elevated reset with select bit high
// [R5] alternate protect: elevated line nine and output gate, select low
// [R6] alternate unprotect: elevated line nine and output gate, select high
// [R7] host runs protect verification after each protect operation; the code leaves OP_VERIFY to software and only clears the verified bit
// [R8] device unprotects all sectors at once
// [R9] host protects all unprotected sectors before first unprotect write; the code leaves op order to software
// [R10] host re-protects each group wanted protected after unprotect; the code leaves op order to software
// [R11] elevated reset lets protected sectors be programmed temporarily
// [R12] removing elevated reset restores earlier protection
// [R13] guard pin low blocks the two outermost boot sectors
// [R14] outermost sectors: lowest in bottom boot, highest in top boot
// [R15] guard pin high follows last stored state of outermost sectors
// [R16] lock indicator on data bit seven, fixed, one means factory locked
// [R17] after enter sequence boot addresses show security area
// [R18] reset or power-up drops security mapping
// [R19] security area spans 256 bytes, 128 words
// [R20] factory-locked security area refuses every change
// [R21] serial id block at fixed low or high addresses
// [R22] security area programs only by full program sequence
// [R23] host issues exit sequence to leave security mapping; the code has no exit sequence operation and leaves it to software
// [R24] each elevated-voltage condition is a separate digital qualifier
module flash_protect_host (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic [flash_protect_pkg::ADDR_W-1:0] addr_o,
   output logic [flash_protect_pkg::DATA_W-1:0] dq_out_o,
   output logic dq_oe_n_o,
   input wire logic [flash_protect_pkg::DATA_W-1:0] dq_in_i,
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o,
   output logic reset_n_o,
   output logic reset_elevated_o,
   output logic address_line_nine_elevated_o,
   output logic oe_elevated_o,
   output logic write_guard_boost_pin_o
);
   import flash_protect_pkg::*;

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic go;
      logic [2:0] op;
      logic alt;
      logic wguard;
      logic temp;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic verified;
      logic lockind;
      logic secmap;
      logic [DATA_W-1:0] dq_s1;
      logic [DATA_W-1:0] dq_s2;
      fsm_t st;
      logic [3:0] cnt;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic dq_oe_n;
      logic rst_hv;
      logic a9_hv;
      logic oe_hv;
      logic rst_n;
   } state_t;

   state_t r, next_r;

   function automatic logic is_hv_op(input logic [2:0] op);
      return (op == OP_PROTECT) || (op == OP_UNPROTECT) || (op == OP_VERIFY);
   endfunction

   function automatic logic [ADDR_W-1:0] sel_addr(
      input logic [ADDR_W-1:0] a, input logic [2:0] op);
      logic [ADDR_W-1:0] x;
      x = a;
      x[BIT_SEL] = (op == OP_UNPROTECT); // see [R3] see [R4]
      x[BIT_ONE] = 1'b1;
      x[BIT_ZERO] = 1'b0;
      return x;
   endfunction

   always_comb begin
      next_r = r;
      next_r.dq_s1 = dq_in_i;
      next_r.dq_s2 = r.dq_s1;
      next_r.ack = 1'b0;
      next_r.rst_n = 1'b1; // see [R18]
      // wishbone slave
      if (cyc_i && stb_i && !r.ack) begin
         next_r.ack = 1'b1;
         next_r.rdat = 32'h0;
         unique case (adr_i)
            REG_CTRL: begin
               next_r.rdat[CTRL_OP_LSB +: CTRL_OP_W] = r.op;
               next_r.rdat[CTRL_ALT] = r.alt;
               next_r.rdat[CTRL_WGUARD] = r.wguard;
               // op order is left to software, see [R9] see [R10] see [R23]
               if (we_i && sel_i[0] && r.st == S_IDLE) begin
                  next_r.go = dat_i[CTRL_GO];
                  next_r.op = dat_i[CTRL_OP_LSB +: CTRL_OP_W];
                  next_r.alt = dat_i[CTRL_ALT];
                  next_r.wguard = dat_i[CTRL_WGUARD]; // see [R13] see [R15]
               end
            end
            REG_ADDR: begin
               next_r.rdat[ADDR_W-1:0] = r.addr;
               if (we_i) next_r.addr = dat_i[ADDR_W-1:0];
            end
            REG_WDATA: begin
               next_r.rdat[DATA_W-1:0] = r.wdata;
               if (we_i) next_r.wdata = dat_i[DATA_W-1:0];
            end
            REG_STATUS: begin
               next_r.rdat[STAT_BUSY] = (r.st != S_IDLE) || r.go;
               next_r.rdat[STAT_VERIFIED] = r.verified; // see [R7]
               next_r.rdat[STAT_LOCKIND] = r.lockind; // see [R16]
               next_r.rdat[STAT_SECMAP] = r.secmap;
               next_r.rdat[STAT_RDATA_LSB +: DATA_W] = r.rdata;
            end
            default: next_r.rdat = 32'h0;
         endcase
      end
      // bus cycle sequencer
      unique case (r.st)
         S_IDLE: begin
            if (r.go) begin
               next_r.go = 1'b0;
               next_r.cnt = PHASE_CYC;
               next_r.st = S_SETUP;
               if (r.op == OP_TEMP_ON) begin
                  next_r.temp = 1'b1; // see [R11]
                  next_r.rst_hv = 1'b1;
                  next_r.st = S_IDLE;
               end else if (r.op == OP_TEMP_OFF) begin
                  next_r.temp = 1'b0; // see [R12]
                  next_r.rst_hv = 1'b0;
                  next_r.st = S_IDLE;
               end else if (is_hv_op(r.op)) begin
                  // see [R24] separate qualifiers per pin
                  next_r.rst_hv = !r.alt;
                  next_r.a9_hv = r.alt; // see [R5] see [R6]
                  next_r.oe_hv = r.alt;
               end
            end
         end
         S_SETUP: begin
            next_r.ce_n = 1'b0;
            if (r.op == OP_READ || r.op == OP_VERIFY) begin
               next_r.oe_n = 1'b0;
               next_r.dq_oe_n = 1'b1;
            end else begin
               next_r.we_n = 1'b0;
               next_r.dq_oe_n = 1'b0;
            end
            next_r.cnt = PHASE_CYC;
            next_r.st = S_STROBE;
         end
         S_STROBE: begin
            if (r.cnt != 4'h0) next_r.cnt = r.cnt - 4'h1;
            else begin
               next_r.we_n = 1'b1;
               next_r.oe_n = 1'b1;
               if (r.op == OP_READ) begin
                  next_r.rdata = r.dq_s2;
                  next_r.lockind = r.dq_s2[BIT_LOCKIND];
               end
               if (r.op == OP_VERIFY)
                  next_r.verified = r.dq_s2[BIT_ZERO];
               next_r.cnt = PHASE_CYC;
               next_r.st = S_HOLD;
            end
         end
         S_HOLD: begin
            if (r.cnt != 4'h0) next_r.cnt = r.cnt - 4'h1;
            else begin
               next_r.ce_n = 1'b1;
               next_r.dq_oe_n = 1'b1;
               next_r.rst_hv = r.temp;
               next_r.a9_hv = 1'b0;
               next_r.oe_hv = 1'b0;
               if (r.op == OP_PROTECT) next_r.verified = 1'b0;
               next_r.st = S_IDLE;
            end
         end
      endcase
      if (rst_i) begin
         next_r = '0;
         next_r.st = S_IDLE;
         next_r.ce_n = 1'b1;
         next_r.oe_n = 1'b1;
         next_r.we_n = 1'b1;
         next_r.dq_oe_n = 1'b1;
         next_r.wguard = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      r <= next_r;
   end

   logic [ADDR_W-1:0] out_addr;
   always_comb begin
      out_addr = is_hv_op(r.op) ? sel_addr(r.addr, r.op) : r.addr;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) addr_o <= '0;
      else addr_o <= out_addr;
   end

   assign dat_o = r.rdat;
   assign ack_o = r.ack;
   assign dq_out_o = r.wdata;
   assign dq_oe_n_o = r.dq_oe_n;
   assign ce_n_o = r.ce_n;
   assign oe_n_o = r.oe_n;
   assign we_n_o = r.we_n;
   assign reset_n_o = r.rst_n;
   assign reset_elevated_o = r.rst_hv;
   assign address_line_nine_elevated_o = r.a9_hv;
   assign oe_elevated_o = r.oe_hv;
   assign write_guard_boost_pin_o = r.wguard;
endmodule

// >>> flash_protect_checker.sv
// port assertions for the flash protection controller
`timescale 1ns/100ps
module flash_protect_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic [flash_protect_pkg::ADDR_W-1:0] addr_o,
   input wire logic dq_oe_n_o,
   input wire logic ce_n_o,
   input wire logic oe_n_o,
   input wire logic we_n_o,
   input wire logic reset_elevated_o,
   input wire logic address_line_nine_elevated_o,
   input wire logic oe_elevated_o,
   input wire logic write_guard_boost_pin_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   a_alt_pair: assert property (address_line_nine_elevated_o |-> oe_elevated_o)
      else $error("line nine raised without output gate");
   a_alt_addr: assert property (address_line_nine_elevated_o && !we_n_o
      |-> addr_o[1:0] == 2'b10)
      else $error("alternate method address bits wrong");
   a_write_gate: assert property (!we_n_o |-> oe_n_o && !ce_n_o)
      else $error("write strobe with output enabled");
   a_dq_drive: assert property (!dq_oe_n_o |-> oe_n_o)
      else $error("data driven during read");
   a_we_addr: assert property (!we_n_o && $past(!we_n_o) |-> $stable(addr_o))
      else $error("address moved under write strobe");
   a_rst_pins: assert property (disable iff (1'b0) rst_i |=> ce_n_o
      && write_guard_boost_pin_o && !reset_elevated_o)
      else $error("pins not idle after reset");
   c_alt: cover property (address_line_nine_elevated_o && !we_n_o);
   c_hv: cover property (reset_elevated_o && !we_n_o);
   c_guard: cover property (!write_guard_boost_pin_o && !we_n_o);
endmodule
bind flash_protect_host flash_protect_checker u_chk (.clk_i, .rst_i,
   .cyc_i, .stb_i, .ack_o, .addr_o, .dq_oe_n_o, .ce_n_o, .oe_n_o, .we_n_o,
   .reset_elevated_o, .address_line_nine_elevated_o, .oe_elevated_o,
   .write_guard_boost_pin_o);

// >>> flash_dev_model.sv
// behavioural flash: group protection, guard pin, lock flag
`timescale 1ns/100ps
module flash_dev_model #(parameter bit LOCKED = 1'b1) (
   input wire logic [21:0] a_i,
   input wire logic [15:0] d_i,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic hv_rst_i,
   input wire logic hv_a9_i,
   input wire logic hv_oe_i,
   input wire logic guard_i,
   output logic [15:0] q_o
);
   logic [63:0] prot = '0;
   logic [15:0] mem [logic [21:0]];
   logic [15:0] rd, wd;
   logic [15:0] last = '0;
   logic [21:0] wa;
   logic cmd, lk;
   always @(negedge we_n_i) begin
      wa = a_i;
      wd = d_i;
      cmd = (hv_rst_i || (hv_a9_i && hv_oe_i))
         && a_i[1:0] == 2'b10;
      lk = (prot[a_i[21:16]] && !hv_rst_i)
         || (a_i[21:13] == '0 && !guard_i);
      // guard covers the low boot sectors
   end
   always @(posedge we_n_i) begin
      if (cmd) prot = wa[6] ? '0 : prot | (64'h1 << wa[21:16]);
      else if (!lk) mem[wa] = wd;
   end
   always @* begin
      rd = mem.exists(a_i) ? mem[a_i] : 16'hFFFF;
      if (a_i[1:0] == 2'b10) rd = {8'h00, LOCKED, 6'h00, prot[a_i[21:16]]};
   end
   always @(posedge oe_n_i) last = rd;
   assign q_o = (!ce_n_i && !oe_n_i) ? rd : ~last;
endmodule

// >>> flash_protect_host_test.sv
// self-checking bench for the flash protection controller
`timescale 1ns/100ps
module flash_protect_host_test;
   import flash_protect_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] adr_i = '0;
   logic [31:0] dat_i = '0;
   logic we_i = 1'b0;
   logic [3:0] sel_i = '0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic [31:0] dat_o, lf, rd;
   logic [ADDR_W-1:0] addr_o;
   logic [DATA_W-1:0] dq_out_o, dq_in_i, q, wd;
   logic ack_o, dq_oe_n_o, ce_n_o, oe_n_o, we_n_o, reset_n_o;
   logic reset_elevated_o, address_line_nine_elevated_o, oe_elevated_o;
   logic write_guard_boost_pin_o;
   logic [31:0] exp_q[$], msk_q[$];
   string nm_q[$];
   int errors = 0;
   int compares = 0;
   bit want = 0;
   always #10 clk_i = ~clk_i;
   assign dq_in_i = dq_oe_n_o ? q : dq_out_o;
   flash_protect_host u_dut (.*);
   flash_dev_model u_mem (.a_i(addr_o), .d_i(dq_in_i), .ce_n_i(ce_n_o),
      .oe_n_i(oe_n_o), .we_n_i(we_n_o), .hv_rst_i(reset_elevated_o),
      .hv_a9_i(address_line_nine_elevated_o), .hv_oe_i(oe_elevated_o),
      .guard_i(write_guard_boost_pin_o), .q_o(q));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic report_and_stop;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      adr_i <= a;
      we_i <= w;
      dat_i <= d;
      sel_i <= 4'hF;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1) begin
         errors++;
         report_and_stop();
      end
      rd = dat_o;
      want = 0;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask
   always @(negedge clk_i) begin
      if (want && ack_o === 1'b1 && exp_q.size() > 0) begin
         cmp(nm_q.pop_front(), exp_q.pop_front(), msk_q.pop_front(), dat_o);
      end
   end
   task automatic cmp(input string s, input logic [31:0] e, m, g);
      compares++;
      if ((g & m) !== (e & m)) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", s, e & m, g & m);
      end
   endtask
   task automatic rchk(input string s, input logic [31:0] e, m);
      nm_q.push_back(s);
      exp_q.push_back(e);
      msk_q.push_back(m);
      want = 1;
      wb(REG_STATUS, 1'b0, '0);
   endtask
   task automatic op(input logic [2:0] o, input logic [21:0] a, input bit alt,
      input bit g);
      int n;
      lf = lfsr(lf);
      wd = lf[15:0];
      wb(REG_ADDR, 1'b1, 32'(a));
      wb(REG_WDATA, 1'b1, lf);
      wb(REG_CTRL, 1'b1, 32'({g, alt, o, 1'b1}));
      n = 0;
      do begin
         wb(REG_STATUS, 1'b0, '0);
         n++;
      end while (rd[STAT_BUSY] !== 1'b0 && n < 30);
      if (rd[STAT_BUSY] !== 1'b0) begin
         errors++;
         report_and_stop();
      end
   endtask
   task automatic rback(input logic [21:0] a, input logic [15:0] e);
      op(OP_READ, a, 0, 1);
      rchk("read data", {e, 16'h0}, 32'hFFFF0000);
   endtask
   initial begin
      logic [15:0] d0;
      lf = 32'hB7522E39;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      op(OP_READ, 22'h000002, 0, 1);
      rchk("lock flag", 32'h4, 32'h4);
      op(OP_WRITE, 22'h010000, 0, 1);
      d0 = wd;
      rback(22'h010000, d0);
      op(OP_PROTECT, 22'h010000, 0, 1);
      op(OP_VERIFY, 22'h010000, 0, 1);
      rchk("verify", 32'h2, 32'h2);
      op(OP_WRITE, 22'h010000, 0, 1);
      rback(22'h010000, d0);
      op(OP_WRITE, 22'h018000, 0, 1);
      rback(22'h018000, 16'hFFFF);
      op(OP_TEMP_ON, 0, 0, 1);
      op(OP_WRITE, 22'h010000, 0, 1);
      d0 = wd;
      op(OP_TEMP_OFF, 0, 0, 1);
      rback(22'h010000, d0);
      op(OP_WRITE, 22'h010000, 0, 1);
      rback(22'h010000, d0);
      op(OP_PROTECT, 22'h020000, 1, 1);
      op(OP_VERIFY, 22'h020000, 0, 1);
      rchk("alt verify", 32'h2, 32'h2);
      op(OP_UNPROTECT, 22'h020000, 0, 1);
      op(OP_VERIFY, 22'h010000, 0, 1);
      rchk("unprotect all", 32'h0, 32'h2);
      op(OP_PROTECT, 22'h010000, 0, 1);
      op(OP_UNPROTECT, 22'h010000, 1, 1);
      op(OP_VERIFY, 22'h010000, 0, 1);
      rchk("alt unprotect", 32'h0, 32'h2);
      op(OP_WRITE, 22'h000100, 0, 0);
      rback(22'h000100, 16'hFFFF);
      op(OP_WRITE, 22'h000100, 0, 1);
      rback(22'h000100, wd);
      report_and_stop();
   end
endmodule
